// >>> rtl/par_router.sv
// module: routes axis pulse and direction onto main unit and adapter outputs
//
// Contract
// [RL1] adapter outputs numbered as main unit; axes 1-2 first, 3-4 second
// [RL2] separate-trains mode: destination output carries forward pulse train
// [RL3] separate-trains mode: companion four above carries reverse train
// [RL4] pulse-plus-direction: destination carries pulses, companion direction
// [RL5] destination output n pairs with direction output n plus four
// [RL6] program assigns no other function to reserved direction outputs
// [RL7] homing clear signal shares the axis direction output by default
// [RL8] program moves clear signal elsewhere when it must really be emitted
// [RL9] active pulse instruction drives main output, indicator and adapter
// [RL10] program keeps pulse frequency below drive unit maximum input
// [RL11] direction settles before first pulse and holds until last pulse ends
module par_router
    import par_pkg::*;
#(
    parameter int AXES = NUM_AXES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // output-method switch per adapter, a pin: 0 separate, 1 pulse+dir
    input wire logic [1:0] method_sw,
    // positioning engine, one bit per axis, same clock
    input wire logic [AXES-1:0] axis_active,
    input wire logic [AXES-1:0] axis_pulse,
    input wire logic [AXES-1:0] axis_reverse,
    input wire logic [AXES-1:0] axis_homing,
    input wire logic [AXES-1:0] axis_clear,
    input wire logic [AXES-1:0] clear_moved,
    // outputs
    output logic [2*AXES-1:0] main_out,
    output logic [2*AXES-1:0] main_led,
    output logic [2*AXES-1:0] adp_out,
    output logic [AXES-1:0] pulse_allowed
);
    // switch synchroniser
    logic [1:0] sw_meta_ff;
    logic [1:0] sw_ff;
    logic [AXES-1:0] pulse_q_ff, nxt_pulse_q;
    logic [2*AXES-1:0] nxt_main_out;
    logic [2*AXES-1:0] nxt_adp_out;
    logic [AXES-1:0] allowed_ff, nxt_allowed;
    par_state_t st_ff [AXES];
    par_state_t nxt_st [AXES];
    logic [3:0] cnt_ff [AXES];
    logic [3:0] nxt_cnt [AXES];
    logic [AXES-1:0] dir_ff, nxt_dir;

    // two flops on the switch pin before any use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_meta_ff <= 2'h0;
            sw_ff <= 2'h0;
        end else begin
            sw_meta_ff <= method_sw;
            sw_ff <= sw_meta_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            logic mode;
            logic fwd_o;
            logic rev_o;
            assign mode = sw_ff[g / 2]; // axes 0,1 adapter 1; 2,3 adapter 2 RL1

            // direction hold state: latch before pulses, keep till move ends
            always_comb begin
                nxt_st[g] = st_ff[g];
                nxt_cnt[g] = cnt_ff[g];
                nxt_dir[g] = dir_ff[g];
                nxt_allowed[g] = 1'b0;
                // gate pulses until RUN so none beat the direction level
                nxt_pulse_q[g] = axis_pulse[g] & (st_ff[g] == PAR_RUN);
                case (st_ff[g])
                    PAR_IDLE: begin
                        if (axis_active[g]) begin
                            nxt_dir[g] = axis_reverse[g]; // RL11
                            nxt_cnt[g] = 4'(DIR_SETUP_CYC - 1);
                            nxt_st[g] = PAR_SETUP;
                        end
                    end
                    PAR_SETUP: begin
                        if (!axis_active[g]) begin
                            nxt_st[g] = PAR_IDLE;
                        end else if (cnt_ff[g] == SETUP_W) begin
                            nxt_st[g] = PAR_RUN;
                            nxt_allowed[g] = 1'b1;
                        end else begin
                            nxt_cnt[g] = cnt_ff[g] - 4'h1;
                        end
                    end
                    PAR_RUN: begin
                        nxt_allowed[g] = axis_active[g];
                        // idle only after the last pulse has gone low RL11
                        if (!axis_active[g] && !pulse_q_ff[g]) begin
                            nxt_st[g] = PAR_IDLE;
                        end
                    end
                    default: nxt_st[g] = PAR_IDLE;
                endcase
            end

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    st_ff[g] <= PAR_IDLE;
                    cnt_ff[g] <= 4'h0;
                    dir_ff[g] <= 1'b0;
                    allowed_ff[g] <= 1'b0;
                    pulse_q_ff[g] <= 1'b0;
                end else begin
                    st_ff[g] <= nxt_st[g];
                    cnt_ff[g] <= nxt_cnt[g];
                    dir_ff[g] <= nxt_dir[g];
                    allowed_ff[g] <= nxt_allowed[g];
                    pulse_q_ff[g] <= nxt_pulse_q[g];
                end
            end

            // pulses only pass once direction is settled
            always_comb begin
                fwd_o = 1'b0;
                rev_o = 1'b0;
                if (mode == MODE_SEPARATE) begin
                    fwd_o = pulse_q_ff[g] & ~dir_ff[g]; // RL2
                    rev_o = pulse_q_ff[g] & dir_ff[g]; // RL3
                end else begin
                    fwd_o = pulse_q_ff[g]; // RL4
                    rev_o = (st_ff[g] != PAR_IDLE) ? dir_ff[g] : 1'b0; // RL4
                end
                // homing: clear shares the direction output unless moved RL7
                if (axis_homing[g] && axis_clear[g] && !clear_moved[g]) begin
                    rev_o = 1'b1; // RL7
                end
                nxt_adp_out[g] = fwd_o;
                nxt_adp_out[g + DIR_OFFSET] = rev_o; // RL5
                nxt_main_out[g] = fwd_o; // RL9
                nxt_main_out[g + DIR_OFFSET] = rev_o; // RL9
            end
        end
    endgenerate

    // output registers; indicator mirrors main output so a lamp never lies
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_out <= '0;
            main_led <= '0;
            adp_out <= '0;
            pulse_allowed <= '0;
        end else begin
            main_out <= nxt_main_out; // RL9
            main_led <= nxt_main_out; // RL9
            adp_out <= nxt_adp_out; // RL1
            pulse_allowed <= allowed_ff;
        end
    end

    // checks; each axis picked where the bench drives that mode
    a_led_tracks: assert property ( // RL9
        @(posedge mclk) disable iff (!rst_n)
        main_led == main_out
    ) else $error("led differs from output");
    a_adp_equal: assert property ( // RL1
        @(posedge mclk) disable iff (!rst_n)
        adp_out == main_out
    ) else $error("adapter differs from main");
    a_pair_sep: assert property ( // RL3
        @(posedge mclk) disable iff (!rst_n)
        (sw_ff[0] == MODE_SEPARATE && $stable(sw_ff) && !axis_homing[0])
        |=> !(adp_out[0] && adp_out[4])
    ) else $error("both trains high");
    a_fwd_sep: assert property ( // RL2
        @(posedge mclk) disable iff (!rst_n)
        (sw_ff[0] == MODE_SEPARATE && pulse_q_ff[0] && dir_ff[0])
        |=> !adp_out[0]
    ) else $error("forward pulse while reverse");
    a_pd_pulse: assert property ( // RL4
        @(posedge mclk) disable iff (!rst_n)
        (sw_ff[0] == MODE_PULSE_DIR) |=> adp_out[0] == $past(pulse_q_ff[0])
    ) else $error("pulse train wrong");
    a_setup_wait: assert property ( // RL11
        @(posedge mclk) disable iff (!rst_n)
        (st_ff[0] == PAR_IDLE && axis_active[0]) |=> !pulse_q_ff[0]
    ) else $error("pulse before direction settled");
    a_dir_hold: assert property ( // RL11
        @(posedge mclk) disable iff (!rst_n)
        (st_ff[0] == PAR_RUN) |=> $stable(dir_ff[0])
    ) else $error("direction moved mid move");
    a_clear_share: assert property ( // RL7
        @(posedge mclk) disable iff (!rst_n)
        (axis_homing[2] && axis_clear[2] && !clear_moved[2]) |=> adp_out[6]
    ) else $error("clear not on direction output");
    a_pair_ax3: assert property ( // RL5
        @(posedge mclk) disable iff (!rst_n)
        (sw_ff[1] == MODE_PULSE_DIR && st_ff[3] == PAR_RUN && !axis_homing[3])
        |=> main_out[7] == $past(dir_ff[3])
    ) else $error("axis four pairing lost");
    a_clear_moved: assert property ( // RL7
        @(posedge mclk) disable iff (!rst_n)
        (axis_homing[1] && axis_clear[1] && clear_moved[1] &&
            sw_ff[0] == MODE_SEPARATE && !pulse_q_ff[1]) |=> !adp_out[5]
    ) else $error("relocated clear still on direction output");
    a_pd_dir: assert property ( // RL4
        @(posedge mclk) disable iff (!rst_n)
        (sw_ff[0] == MODE_PULSE_DIR && st_ff[0] == PAR_RUN && !axis_homing[0])
        |=> adp_out[4] == $past(dir_ff[0])
    ) else $error("direction level wrong");
    a_idle_quiet: assert property ( // RL5
        @(posedge mclk) disable iff (!rst_n)
        (st_ff[1] == PAR_IDLE && !pulse_q_ff[1] && !axis_homing[1])
        |=> !adp_out[1] && !adp_out[5]
    ) else $error("idle axis drives its pair");
    a_sep_rev: assert property ( // RL3
        @(posedge mclk) disable iff (!rst_n)
        (sw_ff[1] == MODE_SEPARATE && pulse_q_ff[2] && dir_ff[2] &&
            !axis_homing[2]) |=> adp_out[6] && !adp_out[2]
    ) else $error("reverse train not on companion");
    a_allow_run: assert property ( // RL11
        @(posedge mclk) disable iff (!rst_n)
        (st_ff[0] == PAR_SETUP && cnt_ff[0] == SETUP_W && axis_active[0])
        |=> st_ff[0] == PAR_RUN ##1 pulse_allowed[0]
    ) else $error("run not entered after settle");
    a_setup_cnt: assert property ( // RL11
        @(posedge mclk) disable iff (!rst_n)
        (st_ff[1] == PAR_SETUP) |-> cnt_ff[1] <= 4'(DIR_SETUP_CYC - 1)
    ) else $error("settle count out of range");
    c_run: cover property (@(posedge mclk) st_ff[0] == PAR_RUN);
    c_pd_fwd: cover property (@(posedge mclk) sw_ff[0] && adp_out[0]);
    c_pd_rev: cover property (@(posedge mclk) sw_ff[1] && adp_out[6]);
    c_clear: cover property (@(posedge mclk) axis_homing[2] && adp_out[6]);
    c_sep_rev: cover property (@(posedge mclk) !sw_ff[0] && adp_out[4]);
endmodule : par_router

// >>> rtl/par_pkg.sv
// package: constants for the pulse axis output routing block
package par_pkg;
    localparam int NUM_AXES = 4;
    localparam int DIR_OFFSET = 4;
    localparam int NUM_OUTS = 8;
    // direction settle lead before the first pulse, in ns
    localparam int DIR_SETUP_NS = 100;
    localparam int CLK_PERIOD_NS = 20;
    localparam int DIR_SETUP_CYC =
        (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SETUP_W = 4'h0;
    localparam logic MODE_SEPARATE = 1'b0;
    localparam logic MODE_PULSE_DIR = 1'b1;
    typedef enum logic [1:0] {
        PAR_IDLE,
        PAR_SETUP,
        PAR_RUN
    } par_state_t;
endpackage : par_pkg

// >>> verif/par_drive_model.sv
// drive unit model that counts command pulses per axis
module par_drive_model
    import par_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // pulse input method set at the drive, per adapter
    input wire logic [1:0] method_sw,
    // command lines from the adapter outputs
    input wire logic [7:0] cmd_in,
    // pulse counts per axis
    output logic [3:0][7:0] fwd_cnt,
    output logic [3:0][7:0] rev_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] prev_ff;
    // rising edges counted at mclk; a late direction lands in the wrong count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 8'h00;
            fwd_cnt <= '0;
            rev_cnt <= '0;
        end else begin
            prev_ff <= cmd_in;
            for (int a = 0; a < 4; a++) begin
                if (cmd_in[a] && !prev_ff[a]) begin
                    if (method_sw[a/2] == MODE_PULSE_DIR && cmd_in[a+4])
                        rev_cnt[a] <= rev_cnt[a] + 8'h01;
                    else
                        fwd_cnt[a] <= fwd_cnt[a] + 8'h01;
                end
                if (method_sw[a/2] == MODE_SEPARATE && cmd_in[a+4] &&
                    !prev_ff[a+4])
                    rev_cnt[a] <= rev_cnt[a] + 8'h01;
            end
        end
    end
endmodule : par_drive_model

// >>> verif/testbench.sv
// self-checking bench for the pulse axis output routing block
module testbench import par_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sw = 2'h0;
    logic [3:0] act = 4'h0, pul = 4'h0, rev = 4'h0;
    logic [3:0] hom = 4'h0, clr = 4'h0, mov = 4'h0;
    logic [7:0] mout, mled, aout;
    logic [3:0] pallow;
    logic [3:0][7:0] fcnt, rcnt;
    int fail_count = 0, checks = 0, cyc = 0;
    always #10 mclk = ~mclk;
    par_router dut_u (.mclk(mclk), .rst_n(rst_n), .method_sw(sw),
        .axis_active(act), .axis_pulse(pul), .axis_reverse(rev),
        .axis_homing(hom), .axis_clear(clr), .clear_moved(mov),
        .main_out(mout), .main_led(mled), .adp_out(aout),
        .pulse_allowed(pallow));
    par_drive_model drv_u (.mclk(mclk), .rst_n(rst_n), .method_sw(sw),
        .cmd_in(aout), .fwd_cnt(fcnt), .rev_cnt(rcnt));
    task automatic chk(input string what, input logic [7:0] e, g);
        checks++;
        if (e !== g) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // one move; pulses spaced well apart so the drive keeps up
    task automatic move(input int a, input logic r, input int n);
        logic [7:0] f0, r0;
        f0 = fcnt[a];
        r0 = rcnt[a];
        @(posedge mclk);
        act[a] <= 1'b1;
        rev[a] <= r;
        repeat (4) @(posedge mclk);
        chk("held off", 8'h00, 8'(pallow[a]));
        repeat (4) @(posedge mclk);
        chk("allowed", 8'h01, 8'(pallow[a]));
        chk("dir level", 8'(sw[a/2] & r), 8'(mout[a+4]));
        repeat (n) begin
            pul[a] <= 1'b1;
            @(posedge mclk);
            pul[a] <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        act[a] <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("fwd count", r ? f0 : f0 + 8'(n), fcnt[a]);
        chk("rev count", r ? r0 + 8'(n) : r0, rcnt[a]);
    endtask : move
    // homing clear on an idle axis, relocated or not
    task automatic clear_on_dir(input int a, input logic moved);
        @(posedge mclk);
        hom[a] <= 1'b1;
        clr[a] <= 1'b1;
        mov[a] <= moved;
        repeat (2) @(posedge mclk);
        chk("clear out", 8'(!moved), 8'(mout[a+4]));
        hom[a] <= 1'b0;
        clr[a] <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : clear_on_dir
    // indicator and adapter copies follow the main outputs every cycle
    always @(negedge mclk) begin
        if (rst_n) begin
            chk("led", mout, mled);
            chk("adapter", mout, aout);
        end
    end
    // cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end
    // direction outputs used only as the router drives them
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        move(0, 1'b0, 3);
        move(1, 1'b1, 2);
        sw <= 2'h1;
        repeat (4) @(posedge mclk);
        move(0, 1'b1, 4);
        move(1, 1'b0, 2);
        move(2, 1'b1, 2);
        move(3, 1'b0, 2);
        sw <= 2'h2;
        repeat (4) @(posedge mclk);
        move(3, 1'b1, 3);
        sw <= 2'h0;
        repeat (4) @(posedge mclk);
        clear_on_dir(2, 1'b0);
        clear_on_dir(1, 1'b1);
        give_verdict();
    end
endmodule : testbench
